/* File: vpc_policer_pkg.sv */
// shared constants for the ingress path policer
package vpc_policer_pkg;
	// ----------------------------------------
	// cell header field positions
	// ----------------------------------------
	localparam int HDR_W     = 32;  // header word width
	localparam int VPI_HI    = 27;  // path identifier msb
	localparam int VPI_LO    = 20;  // path identifier lsb
	localparam int VPI_IDX_W = 4;   // table index width
	localparam int VCI_SUB   = 4;   // low channel bits start
	localparam int PTI_USER  = 3;   // payload type msb, 0 for user cells
	localparam int PTI_EFCI  = 2;   // congestion-experienced bit
	localparam int CLP_BIT   = 0;   // loss-priority bit
	localparam int PATHS     = 16;  // policed paths
	localparam int SLOTS     = 64;  // rate-state slots, four per path
	localparam int TIME_W    = 16;  // cell time width
	localparam int THR_W     = 8;   // admission count width
	// ----------------------------------------
	// register map, byte offsets
	// ----------------------------------------
	localparam logic [2:0] REG_CTRL  = 3'h0;  // 0x00 global control
	localparam logic [2:0] REG_SEL   = 3'h1;  // 0x04 path select
	localparam logic [2:0] REG_RATE  = 3'h2;  // 0x08 increment, tolerance
	localparam logic [2:0] REG_MODE  = 3'h3;  // 0x0C path mode, threshold
	localparam logic [2:0] REG_ADMIT = 3'h4;  // 0x10 admission command
	localparam logic [2:0] REG_DISC  = 3'h5;  // 0x14 discard count
	localparam logic [2:0] REG_INVAL = 3'h6;  // 0x18 invalid path count
	localparam logic [2:0] REG_TAGC  = 3'h7;  // 0x1C tagged count
	localparam int ADDR_LO = 2;  // word index lsb
	localparam int ADDR_HI = 4;  // word index msb
	// ----------------------------------------
	// control and mode bits
	// ----------------------------------------
	localparam int CTL_POLICE = 0;  // policing on
	localparam int CTL_SELDSC = 1;  // congestion discard of low priority
	localparam int CTL_SHAPE  = 2;  // delay instead of discard
	localparam int CTL_AUTOREL = 3; // release path on aggregate violation
	localparam int CTL_W      = 4;
	localparam int MD_VALID   = 0;
	localparam int MD_TAG     = 1;
	localparam int MD_DUAL    = 2;
	localparam int MD_TERM    = 3;
	localparam int MD_W       = 4;
	localparam int MD_THR_LO  = 8;
	localparam int ADM_ADMIT  = 0;
	localparam int ADM_REL    = 1;
	localparam int ADM_ACC    = 8;
	localparam logic [CTL_W-1:0] CTRL_RST = 4'h0;
endpackage : vpc_policer_pkg

/* File: vpc_ingress_cell_policer.sv */
// ingress path policer with admission counters and an ahb-lite register slave
//
// Contract
// - policing checks each cell's path is active
// - peak rate enforced per path
// - conforming cells forwarded unchanged
// - tagging only rewrites priority zero to one
// - optional second instance on priority-zero cells
// - tagged cells merge into low-priority stream
// - aggregate violators discarded, or held back instead when shaping is on
// - forwarded cells keep arrival order
// - optional delaying instead of discarding
// - congestion may drop low-priority cells
// - congestion bit never cleared, may be set
// - terminating paths policed per channel; here by the two low channel bits, four slots per path
// - policing optional, ingress only
// - admit channel only below path threshold
// - offending connection may be released
// - one rate algorithm per policed stream
// - aggregate both priorities, substream priority zero
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module vpc_ingress_cell_policer (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        cell_valid,
	output logic             cell_ready,
	input  wire logic [31:0] cell_hdr,
	input  wire logic        congested,
	output logic             cell_out_valid,
	output logic [31:0]      cell_out_hdr
);
	// ----------------------------------------
	// types and functions
	// ----------------------------------------
	typedef enum logic {ST_RUN, ST_HOLD} state_type;
	typedef logic [vpc_policer_pkg::TIME_W-1:0] time_type;

	// late or within tolerance counts as conforming
	function automatic logic gcra_ok(input time_type tat, input time_type now,
		input time_type tol);
		time_type d;
		d = tat - now;
		gcra_ok = d[vpc_policer_pkg::TIME_W-1] || (d <= tol);
	endfunction : gcra_ok

	// theoretical arrival advances from the later of tat and now
	function automatic time_type gcra_next(input time_type tat, input time_type now,
		input time_type incr);
		time_type d;
		d = tat - now;
		gcra_next = (d[vpc_policer_pkg::TIME_W-1] ? now : tat) + incr;
	endfunction : gcra_next

	// ----------------------------------------
	// storage
	// ----------------------------------------
	state_type st_q;                                        // hold state
	logic [31:0]  held_q;                                   // delayed header
	logic         ready_q, ovalid_q, readyout_q;            // port flops
	logic [31:0]  ohdr_q, rdata_q;                          // port flops
	time_type     now_q;                                    // cell time
	logic [vpc_policer_pkg::CTL_W-1:0] ctrl_q;              // global control
	logic [vpc_policer_pkg::VPI_IDX_W-1:0] sel_q;           // selected path
	time_type     incr_q [vpc_policer_pkg::PATHS];          // peak emission interval
	time_type     tol_q  [vpc_policer_pkg::PATHS];          // delay tolerance
	time_type     incr0_q [vpc_policer_pkg::PATHS];         // priority-zero emission interval
	logic [vpc_policer_pkg::MD_W-1:0] mode_q [vpc_policer_pkg::PATHS];
	logic [vpc_policer_pkg::THR_W-1:0] thr_q [vpc_policer_pkg::PATHS];
	logic [vpc_policer_pkg::THR_W-1:0] cnt_q [vpc_policer_pkg::PATHS];
	logic [vpc_policer_pkg::PATHS-1:0] rel_q;               // released paths
	time_type     tat_a_q [vpc_policer_pkg::SLOTS];         // aggregate state
	time_type     tat_b_q [vpc_policer_pkg::SLOTS];         // priority-zero state
	logic         acc_q;                                    // last admission result
	logic [31:0]  disc_q, inval_q, tagc_q;                  // event counts
	logic         wen_q;                                    // write data phase
	logic [2:0]   widx_q;                                   // write register index

	// ----------------------------------------
	// cell decision
	// ----------------------------------------
	wire          hold_w  = (st_q == ST_HOLD);
	wire  [31:0]  hdr_w   = hold_w ? held_q : cell_hdr;
	wire          take_w  = hold_w | (cell_valid & ready_q);
	wire  [7:0]   vpi_w   = hdr_w[vpc_policer_pkg::VPI_HI:vpc_policer_pkg::VPI_LO];
	wire  [3:0]   pidx_w  = vpi_w[3:0];
	wire  [3:0]   md_w    = mode_q[pidx_w];
	wire          path_ok = (vpi_w[7:4] == 4'h0) & md_w[vpc_policer_pkg::MD_VALID]
		& ~rel_q[pidx_w];
	// terminating paths get a slot per value of the two low channel bits
	wire  [1:0]   sub_w   = md_w[vpc_policer_pkg::MD_TERM] ?
		hdr_w[vpc_policer_pkg::VCI_SUB+1:vpc_policer_pkg::VCI_SUB] : 2'h0;
	wire  [5:0]   slot_w  = {pidx_w, sub_w};
	wire          clp_w   = hdr_w[vpc_policer_pkg::CLP_BIT];
	wire          user_w  = ~hdr_w[vpc_policer_pkg::PTI_USER];
	wire          pol_w   = ctrl_q[vpc_policer_pkg::CTL_POLICE];
	wire          ok_a    = gcra_ok(tat_a_q[slot_w], now_q, tol_q[pidx_w]);
	wire          ok_b    = gcra_ok(tat_b_q[slot_w], now_q, tol_q[pidx_w]);
	wire          inval_w = pol_w & ~path_ok;
	wire          over_a  = pol_w & path_ok & ~ok_a;
	wire          wait_w  = over_a & ctrl_q[vpc_policer_pkg::CTL_SHAPE];
	wire          drop_a  = over_a & ~ctrl_q[vpc_policer_pkg::CTL_SHAPE];
	wire          fail_b  = pol_w & path_ok & ok_a & md_w[vpc_policer_pkg::MD_DUAL]
		& ~clp_w & ~ok_b;
	wire          tag_w   = fail_b & md_w[vpc_policer_pkg::MD_TAG];
	wire          drop_b  = fail_b & ~md_w[vpc_policer_pkg::MD_TAG];
	wire          cdrop_w = congested & ctrl_q[vpc_policer_pkg::CTL_SELDSC]
		& (clp_w | tag_w);
	wire          drop_w  = inval_w | drop_a | drop_b | cdrop_w;
	wire          fwd_w   = take_w & ~wait_w & ~drop_w;
	wire          upd_a   = fwd_w & pol_w & path_ok;
	wire          upd_b   = upd_a & ~clp_w & ok_b & md_w[vpc_policer_pkg::MD_DUAL];
	// congestion bit only ever ORed in; tagged cells leave with clp one
	wire  [31:0]  out_w   = {hdr_w[31:3], hdr_w[2] | (congested & user_w), hdr_w[1],
		clp_w | tag_w};
	wire          rel_set = take_w & drop_a & ctrl_q[vpc_policer_pkg::CTL_AUTOREL];

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire          ap_w    = hsel & htrans[1] & hready;
	wire          hit_w   = (haddr[31:5] == 27'h0);
	wire  [2:0]   ridx_w  = haddr[vpc_policer_pkg::ADDR_HI:vpc_policer_pkg::ADDR_LO];
	wire  [31:0]  rd_w    = ~hit_w ? 32'h0 :
		(ridx_w == vpc_policer_pkg::REG_CTRL)  ? {28'h0, ctrl_q} :
		(ridx_w == vpc_policer_pkg::REG_SEL)   ? {28'h0, sel_q} :
		(ridx_w == vpc_policer_pkg::REG_RATE)  ? {incr_q[sel_q], tol_q[sel_q]} :
		(ridx_w == vpc_policer_pkg::REG_MODE)  ? {incr0_q[sel_q], thr_q[sel_q], 3'h0,
			rel_q[sel_q], mode_q[sel_q]} :
		(ridx_w == vpc_policer_pkg::REG_ADMIT) ? {23'h0, acc_q, cnt_q[sel_q]} :
		(ridx_w == vpc_policer_pkg::REG_DISC)  ? disc_q :
		(ridx_w == vpc_policer_pkg::REG_INVAL) ? inval_q : tagc_q;
	wire          wr_mode = wen_q & (widx_q == vpc_policer_pkg::REG_MODE);
	wire          wr_adm  = wen_q & (widx_q == vpc_policer_pkg::REG_ADMIT);
	wire          adm_ok  = cnt_q[sel_q] < thr_q[sel_q];

	assign hreadyout      = readyout_q;
	assign hresp          = 1'b0;
	assign hrdata         = rdata_q;
	assign cell_ready     = ready_q;
	assign cell_out_valid = ovalid_q;
	assign cell_out_hdr   = ohdr_q;

	// ----------------------------------------
	// cell pipeline
	// ----------------------------------------
	// one decision per cycle, held cell blocks later ones
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q     <= ST_RUN;
			ready_q  <= 1'b0;
			ovalid_q <= 1'b0;
			ohdr_q   <= 32'h0;
			held_q   <= 32'h0;
			now_q    <= '0;
		end else begin
			now_q    <= now_q + 16'h1;
			st_q     <= (take_w & wait_w) ? ST_HOLD : ST_RUN;
			ready_q  <= ~(take_w & wait_w);
			held_q   <= hdr_w;
			ovalid_q <= fwd_w;
			ohdr_q   <= out_w;
		end
	end

	// rate state per slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < vpc_policer_pkg::SLOTS; i++) begin
				tat_a_q[i] <= '0;
				tat_b_q[i] <= '0;
			end
		end else begin
			if (upd_a)
				tat_a_q[slot_w] <= gcra_next(tat_a_q[slot_w], now_q, incr_q[pidx_w]);
			if (upd_b)
				tat_b_q[slot_w] <= gcra_next(tat_b_q[slot_w], now_q, incr0_q[pidx_w]);
		end
	end

	// event counters
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			disc_q  <= 32'h0;
			inval_q <= 32'h0;
			tagc_q  <= 32'h0;
		end else begin
			if (take_w & inval_w)
				inval_q <= inval_q + 32'h1;
			if (take_w & drop_w & ~inval_w)
				disc_q <= disc_q + 32'h1;
			if (fwd_w & tag_w)
				tagc_q <= tagc_q + 32'h1;
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// zero wait states; read data prepared in the address phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			readyout_q <= 1'b0;
			rdata_q    <= 32'h0;
			wen_q      <= 1'b0;
			widx_q     <= 3'h0;
		end else begin
			readyout_q <= 1'b1;
			wen_q      <= ap_w & hwrite & hit_w;
			widx_q     <= ridx_w;
			if (ap_w & ~hwrite)
				rdata_q <= rd_w;
		end
	end

	// configuration writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= vpc_policer_pkg::CTRL_RST;
			sel_q  <= 4'h0;
			for (int i = 0; i < vpc_policer_pkg::PATHS; i++) begin
				incr_q[i] <= '0;
				tol_q[i]  <= '0;
				mode_q[i] <= 4'h0;
				thr_q[i]  <= 8'h0;
				incr0_q[i] <= '0;
			end
		end else if (wen_q) begin
			unique case (widx_q)
				vpc_policer_pkg::REG_CTRL: ctrl_q <= hwdata[3:0];
				vpc_policer_pkg::REG_SEL:  sel_q  <= hwdata[3:0];
				vpc_policer_pkg::REG_RATE: begin
					incr_q[sel_q] <= hwdata[31:16];
					tol_q[sel_q]  <= hwdata[15:0];
				end
				vpc_policer_pkg::REG_MODE: begin
					mode_q[sel_q] <= hwdata[3:0];
					thr_q[sel_q]  <= hwdata[15:8];
					incr0_q[sel_q] <= hwdata[31:16];  // own rate for the substream
				end
				default: ;
			endcase
		end
	end

	// released paths: hardware set wins over the clear by a mode write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rel_q <= 16'h0;
		end else begin
			for (int i = 0; i < vpc_policer_pkg::PATHS; i++) begin
				if (rel_set && pidx_w == 4'(i))
					rel_q[i] <= 1'b1;
				else if (wr_mode && sel_q == 4'(i))
					rel_q[i] <= 1'b0;
			end
		end
	end

	// admission counters per path
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 1'b0;
			for (int i = 0; i < vpc_policer_pkg::PATHS; i++)
				cnt_q[i] <= 8'h0;
		end else if (wr_adm) begin
			if (hwdata[vpc_policer_pkg::ADM_ADMIT]) begin
				acc_q <= adm_ok;
				if (adm_ok)
					cnt_q[sel_q] <= cnt_q[sel_q] + 8'h1;
			end else if (hwdata[vpc_policer_pkg::ADM_REL] && cnt_q[sel_q] != 8'h0) begin
				cnt_q[sel_q] <= cnt_q[sel_q] - 8'h1;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_agg_discard: assert property (@(posedge ref_clk) disable iff (!rst_n)
		take_w & drop_a |=> !cell_out_valid)
		else $error("aggregate violator forwarded");
	a_pass_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
		take_w & ~pol_w & ~congested |=> cell_out_valid && cell_out_hdr == $past(hdr_w))
		else $error("conforming cell altered or lost");
	a_tag_clp0: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fwd_w & tag_w |=> cell_out_hdr[0] && !$past(clp_w))
		else $error("tag on wrong cell");
	a_efci_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fwd_w & hdr_w[2] |=> cell_out_hdr[2])
		else $error("congestion bit cleared");
	a_invalid_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		take_w & inval_w |=> !cell_out_valid ##0 inval_q == $past(inval_q) + 32'h1)
		else $error("invalid path cell forwarded or uncounted");
	a_admit_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_adm & hwdata[vpc_policer_pkg::ADM_ADMIT] & ~adm_ok
		|=> !acc_q && cnt_q[sel_q] == $past(cnt_q[sel_q]))
		else $error("admission above threshold");
	a_hold_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
		take_w & wait_w |=> !cell_ready && !cell_out_valid && held_q == $past(hdr_w))
		else $error("delayed cell not held");
	a_order_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fwd_w |=> cell_out_valid && cell_out_hdr[31:3] == $past(hdr_w[31:3]))
		else $error("forwarded cell out of order");
	a_sub_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		take_w & drop_b |=> !cell_out_valid)
		else $error("substream violator forwarded");
endmodule : vpc_ingress_cell_policer

/* File: cell_source.sv */
// far-side cell source model feeding the policer
`timescale 1ns/1ns
module cell_source (
	input  wire logic        ref_clk,
	input  wire logic        cell_ready,
	output logic             cell_valid,
	output logic [31:0]      cell_hdr
);
	// idle until a cell is offered
	initial begin
		cell_valid = 1'b0;
		cell_hdr   = 32'h0;
	end
	// offer one header and hold it until the policer takes it
	task send(input logic [31:0] h);
		cell_valid <= 1'b1;
		cell_hdr   <= h;
		do @(posedge ref_clk); while (cell_ready !== 1'b1);
	endtask : send
	// release the line; header turns to junk so stale values never match
	task stop();
		cell_valid <= 1'b0;
		cell_hdr   <= ~cell_hdr;
	endtask : stop
endmodule : cell_source

/* File: vpc_ingress_cell_policer_tb.sv */
// self-checking bench for the ingress path policer
`timescale 1ns/1ns
module vpc_ingress_cell_policer_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        ref_clk;
	logic        rst_n;
	logic        hsel;
	logic        hwrite;
	logic        congested;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        cell_valid;
	logic        cell_ready;
	logic [31:0] cell_hdr;
	logic        cell_out_valid;
	logic [31:0] cell_out_hdr;
	logic [31:0] outq[$];   // forwarded headers in order
	time         tq[$];     // their arrival times
	logic [31:0] rd;        // last read data
	int          n_mismatch;
	int          compares;
	// ----------------------------------------
	// instances
	// ----------------------------------------
	vpc_ingress_cell_policer u_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cell_valid(cell_valid),
		.cell_ready(cell_ready), .cell_hdr(cell_hdr), .congested(congested),
		.cell_out_valid(cell_out_valid), .cell_out_hdr(cell_out_hdr));
	cell_source u_src (.ref_clk(ref_clk), .cell_ready(cell_ready),
		.cell_valid(cell_valid), .cell_hdr(cell_hdr));
	// clock, 50 ns period
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// collect every forwarded cell
	always @(posedge ref_clk) begin
		if (cell_out_valid === 1'b1) begin
			outq.push_back(cell_out_hdr);
			tq.push_back($time);
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task test_done();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one single ahb-lite transfer, zero or more wait states
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk(32'(hresp), 32'h0);
	endtask : ahb
	function automatic logic [31:0] hdr(input logic [7:0] p, input logic [15:0] c,
		input logic [2:0] pt, input logic cl);
		return {4'h0, p, c, pt, cl};
	endfunction : hdr
	// control word, path select, rate and mode
	task cfg(input logic [31:0] ctl, input logic [7:0] p, input logic [31:0] rate,
		input logic [31:0] mode);
		ahb(1'b1, 32'h00, ctl);
		ahb(1'b1, 32'h04, {24'h0, p});
		ahb(1'b1, 32'h08, rate);
		ahb(1'b1, 32'h0C, mode);
	endtask : cfg
	task pop_chk(input logic [31:0] e);
		chk(outq.size() == 0 ? ~e : outq.pop_front(), e);
	endtask : pop_chk
	// let outputs land, then insist nothing extra came out
	task settle();
		repeat (8) @(posedge ref_clk);
	endtask : settle
	task drained();
		chk(32'(outq.size()), 32'h0);
		tq.delete();
	endtask : drained
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_rate();
		cfg(32'h1, 8'h01, 32'h0004_0000, 32'h1);
		ahb(1'b0, 32'h08, 32'h0);
		chk(rd, 32'h0004_0000);
		ahb(1'b0, 32'h40, 32'h0);
		chk(rd, 32'h0);
		u_src.send(hdr(8'h01, 16'h0011, 3'h0, 1'b0));
		u_src.send(hdr(8'h01, 16'h0012, 3'h0, 1'b1));
		u_src.send(hdr(8'h01, 16'h0013, 3'h0, 1'b0));
		u_src.stop();
		repeat (6) @(posedge ref_clk);
		u_src.send(hdr(8'h01, 16'h0014, 3'h0, 1'b0));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h01, 16'h0011, 3'h0, 1'b0));
		pop_chk(hdr(8'h01, 16'h0014, 3'h0, 1'b0));
		ahb(1'b0, 32'h14, 32'h0);
		chk(rd, 32'h2);
		drained();
	endtask : t_rate
	task t_valid();
		cfg(32'h1, 8'h02, 32'h0001_0002, 32'h0);
		u_src.send(hdr(8'h02, 16'h0001, 3'h0, 1'b0));
		u_src.send(hdr(8'h20, 16'h0001, 3'h0, 1'b0));
		u_src.stop();
		settle();
		ahb(1'b0, 32'h18, 32'h0);
		chk(rd, 32'h2);
		drained();
		// policing off: even an unknown path passes untouched and uncounted
		ahb(1'b1, 32'h00, 32'h0);
		u_src.send(hdr(8'h20, 16'h0002, 3'h0, 1'b0));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h20, 16'h0002, 3'h0, 1'b0));
		ahb(1'b0, 32'h18, 32'h0);
		chk(rd, 32'h2);
		drained();
	endtask : t_valid
	task t_term();
		cfg(32'h1, 8'h08, 32'h0004_0000, 32'h9);
		u_src.send(hdr(8'h08, 16'h0000, 3'h0, 1'b0));
		u_src.send(hdr(8'h08, 16'h0001, 3'h0, 1'b0));
		u_src.send(hdr(8'h08, 16'h0004, 3'h0, 1'b0));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h08, 16'h0000, 3'h0, 1'b0));
		pop_chk(hdr(8'h08, 16'h0001, 3'h0, 1'b0));
		drained();
	endtask : t_term
	task t_cong();
		cfg(32'h3, 8'h04, 32'h0001_0002, 32'h1);
		congested <= 1'b1;
		u_src.send(hdr(8'h04, 16'h0001, 3'h0, 1'b0));
		u_src.send(hdr(8'h04, 16'h0002, 3'h0, 1'b1));
		u_src.send(hdr(8'h04, 16'h0003, 3'h4, 1'b0));
		u_src.stop();
		@(posedge ref_clk);
		congested <= 1'b0;
		u_src.send(hdr(8'h04, 16'h0004, 3'h2, 1'b1));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h04, 16'h0001, 3'h2, 1'b0));
		pop_chk(hdr(8'h04, 16'h0003, 3'h4, 1'b0));
		pop_chk(hdr(8'h04, 16'h0004, 3'h2, 1'b1));
		drained();
	endtask : t_cong
	// substream runs at a quarter of the aggregate rate
	task t_tag();
		cfg(32'h1, 8'h03, 32'h0001_0000, 32'h0004_0007);
		u_src.send(hdr(8'h03, 16'h0001, 3'h0, 1'b0));
		u_src.send(hdr(8'h03, 16'h0002, 3'h0, 1'b0));
		u_src.send(hdr(8'h03, 16'h0003, 3'h0, 1'b1));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h03, 16'h0001, 3'h0, 1'b0));
		pop_chk(hdr(8'h03, 16'h0002, 3'h0, 1'b1));
		pop_chk(hdr(8'h03, 16'h0003, 3'h0, 1'b1));
		ahb(1'b0, 32'h1C, 32'h0);
		chk(rd, 32'h1);
		drained();
		// tagging off: the substream violator is dropped instead
		ahb(1'b1, 32'h0C, 32'h0004_0005);
		u_src.send(hdr(8'h03, 16'h0005, 3'h0, 1'b0));
		u_src.send(hdr(8'h03, 16'h0006, 3'h0, 1'b0));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h03, 16'h0005, 3'h0, 1'b0));
		drained();
	endtask : t_tag
	task t_shape();
		cfg(32'h5, 8'h06, 32'h0003_0000, 32'h1);
		u_src.send(hdr(8'h06, 16'h0001, 3'h0, 1'b0));
		u_src.send(hdr(8'h06, 16'h0002, 3'h0, 1'b0));
		u_src.stop();
		settle();
		chk(32'((tq.size() > 1) && (tq[1] - tq[0] >= 150)), 32'h1);
		pop_chk(hdr(8'h06, 16'h0001, 3'h0, 1'b0));
		pop_chk(hdr(8'h06, 16'h0002, 3'h0, 1'b0));
		drained();
	endtask : t_shape
	task t_release();
		cfg(32'h9, 8'h07, 32'h0008_0000, 32'h1);
		u_src.send(hdr(8'h07, 16'h0001, 3'h0, 1'b0));
		u_src.send(hdr(8'h07, 16'h0002, 3'h0, 1'b0));
		u_src.send(hdr(8'h07, 16'h0003, 3'h0, 1'b0));
		u_src.stop();
		settle();
		ahb(1'b0, 32'h0C, 32'h0);
		chk(32'(rd[4]), 32'h1);
		ahb(1'b1, 32'h0C, 32'h1);
		repeat (10) @(posedge ref_clk);
		u_src.send(hdr(8'h07, 16'h0004, 3'h0, 1'b0));
		u_src.stop();
		settle();
		pop_chk(hdr(8'h07, 16'h0001, 3'h0, 1'b0));
		pop_chk(hdr(8'h07, 16'h0004, 3'h0, 1'b0));
		drained();
	endtask : t_release
	task t_admit();
		ahb(1'b1, 32'h04, 32'h5);
		ahb(1'b1, 32'h0C, 32'h0000_0201);
		for (int i = 0; i < 3; i++) begin
			ahb(1'b1, 32'h10, 32'h1);
			ahb(1'b0, 32'h10, 32'h0);
			chk(32'(rd[8]), 32'(i < 2));
		end
		chk(32'(rd[7:0]), 32'h2);
		ahb(1'b1, 32'h10, 32'h2);
		ahb(1'b0, 32'h10, 32'h0);
		chk(32'(rd[7:0]), 32'h1);
	endtask : t_admit
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n      = 1'b0;
		hsel       = 1'b0;
		htrans     = 2'h0;
		haddr      = 32'h0;
		hwrite     = 1'b0;
		hwdata     = 32'h0;
		congested  = 1'b0;
		n_mismatch = 0;
		compares   = 0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_rate();
		t_valid();
		t_term();
		t_cong();
		t_tag();
		t_shape();
		t_release();
		t_admit();
		test_done();
	end
	initial begin
		#2000000;
		n_mismatch++;
		test_done();
	end
endmodule : vpc_ingress_cell_policer_tb
